// ===== src/eiu_top.sv
// External pin interrupt unit: three dedicated pins and 32 pin-change inputs.
// Assumes one 50 MHz clock, a byte register port and a core that acknowledges
// each taken request with a one-cycle pulse.
//
// Summary of operation
// [R1] Group 3..0 requests raise on toggles of enabled pins 31:24..7:0.
// [R2] Per-pin mask bits choose which pin-change inputs feed their group.
// [R3] Pin-change events can wake the part in any sleep mode.
// [R4] Enabled interrupts fire even when the pin is driven as an output.
// [R5] Two-bit sense per pin: low, any edge, falling, rising; bits 5:0.
// [R6] Low-level sense keeps requesting while the pin stays low.
// [R7] Level and edge detection on dedicated pins can wake the part.
// [R8] A low level gone before start-up ends gives no interrupt.
// [R9] Dedicated interrupt needs global enable and own enable, bits 2:0.
// [R10] Edges are caught; pulses above minimum width always interrupt.
// [R11] Outside source holds a low level until the current instruction ends.
// [R12] Software disables, changes sense, clears flag, then re-enables.
// [R13] A triggering edge or change sets the dedicated pin's flag.
// [R14] Flag with both enables set sends the core to the pin's vector.
// [R15] Flag clears on routine entry or on writing a one.
// [R16] In low-level sense the pin's flag always reads cleared.
// [R17] Sleeping with a pin disabled gates its input; change may set flag.
// [R18] Top two sense register bits are reserved and read zero.
// [R19] Each group has its own enable, gated by the global enable.
// [R20] Group flag sets on change; clears on routine entry or one written.
// [R21] All pin-change mask bits reset to zero.
// [R22] Pin events pass a synchroniser before reaching the flags.
// [R23] Each flag, its enable and the global enable form one request line.
`timescale 1ns/10ps

module eiu_top (
  input wire logic CLK, // System clock, 50 MHz
  input wire logic SRST, // Synchronous reset, high
  input wire logic [eiu_pkg::EIU_AW-1:0] ADDR, // Register address
  input wire logic [eiu_pkg::EIU_DW-1:0] WDATA, // Write data
  input wire logic WR, // Write strobe
  input wire logic RD, // Read strobe
  output logic [eiu_pkg::EIU_DW-1:0] RDATA, // Read data, cycle after RD
  input wire logic [eiu_pkg::EIU_N_DED-1:0] DED_IRQ_PINS, // Dedicated pins
  input wire logic [eiu_pkg::EIU_N_PC-1:0] PIN_CHANGE_INPUTS, // Change pins
  input wire logic GIE, // Global interrupt enable of core
  input wire logic SLEEP, // Core is in a sleep mode
  input wire logic [eiu_pkg::EIU_N_REQ-1:0] IRQ_ACK, // Routine entry pulses
  output logic [eiu_pkg::EIU_N_REQ-1:0] IRQ_REQ, // Requests to core
  output logic WAKE // Wake request to clock control
);
  import eiu_pkg::*;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------

  // OR-reduce each 8-bit group of a 32-bit vector
  function automatic logic [EIU_N_GRP-1:0] grp_any(input logic [EIU_N_PC-1:0] v);
    logic [EIU_N_GRP-1:0] r;
    r = '0;
    for (int g = 0; g < EIU_N_GRP; g++) begin
      r[g] = |v[g*EIU_GRP_W +: EIU_GRP_W];
    end
    return r;
  endfunction

  // Edge trigger of one dedicated pin for its sense code
  function automatic logic edge_hit(input eiu_sense_t s, input logic now,
                                    input logic old);
    logic r;
    r = 1'b0;
    unique case (s)
      EIU_SENSE_LOW: r = 1'b0;
      EIU_SENSE_ANY: r = now ^ old;
      EIU_SENSE_FALL: r = old & ~now;
      EIU_SENSE_RISE: r = now & ~old;
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------
  eiu_pin_if #(.W(EIU_N_DED)) ded_if ();
  eiu_pin_if #(.W(EIU_N_PC)) pc_if ();

  // Pins read regardless of port direction
  eiu_sync #(.W(EIU_N_DED)) u_ded_sync ( // R4 R22
    .clk(CLK),
    .srst(SRST),
    .async_in(DED_IRQ_PINS),
    .pin(ded_if)
  );

  eiu_sync #(.W(EIU_N_PC)) u_pc_sync ( // R4 R22
    .clk(CLK),
    .srst(SRST),
    .async_in(PIN_CHANGE_INPUTS),
    .pin(pc_if)
  );

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [5:0] sense_q;
  logic [5:0] sense_d;
  logic [EIU_N_DED-1:0] ded_en_q;
  logic [EIU_N_DED-1:0] ded_en_d;
  logic [EIU_N_DED-1:0] ded_flag_q;
  logic [EIU_N_DED-1:0] ded_flag_d;
  logic [EIU_N_DED-1:0] ded_gated_q;
  logic [EIU_N_DED-1:0] ded_gated_d;
  logic [EIU_N_GRP-1:0] grp_en_q;
  logic [EIU_N_GRP-1:0] grp_en_d;
  logic [EIU_N_GRP-1:0] grp_flag_q;
  logic [EIU_N_GRP-1:0] grp_flag_d;
  logic [EIU_N_PC-1:0] mask_q;
  logic [EIU_N_PC-1:0] mask_d;
  logic [EIU_DW-1:0] rdata_q;
  logic [EIU_DW-1:0] rdata_d;
  logic [EIU_N_REQ-1:0] req_q;
  logic [EIU_N_REQ-1:0] req_d;
  logic wake_q;
  logic wake_d;
  logic [2:0] warm_q;
  logic [2:0] warm_d;

  // Combinational helpers
  logic [EIU_N_DED-1:0] ded_gated_now;
  logic [EIU_N_DED-1:0] ded_level_mode;
  logic [EIU_N_DED-1:0] ded_event;
  logic [EIU_N_DED-1:0] ded_low_req;
  logic [EIU_N_DED-1:0] ded_flag_view;
  logic [EIU_N_GRP-1:0] grp_event;
  logic [EIU_N_PC-1:0] pc_toggle;
  logic [EIU_DW-1:0] status_byte;
  logic wr_sense;
  logic wr_en;
  logic wr_flags;
  logic wr_grp_en;
  logic wr_grp_flags;

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  assign wr_sense = WR && (ADDR == EIU_ADR_SENSE);
  assign wr_en = WR && (ADDR == EIU_ADR_ENABLE);
  assign wr_flags = WR && (ADDR == EIU_ADR_FLAGS);
  assign wr_grp_en = WR && (ADDR == EIU_ADR_GRP_EN);
  assign wr_grp_flags = WR && (ADDR == EIU_ADR_GRP_FLAGS);

  // ----------------------------------------------------------------
  // Warm-up after reset
  // ----------------------------------------------------------------

  // Shift in ones; edges count only once synchronisers hold real levels
  always_comb begin
    warm_d = {warm_q[1:0], 1'h1};
  end

  // Warm-up register, so reset zeros never look like a pin edge
  always_ff @(posedge CLK) begin
    if (SRST) begin
      warm_q <= '0;
    end else begin
      warm_q <= warm_d;
    end
  end

  // ----------------------------------------------------------------
  // Event detection
  // ----------------------------------------------------------------

  // Input gating while asleep with pin disabled, then edge per sense
  always_comb begin
    ded_gated_now = ded_if.lvl & ~({EIU_N_DED{SLEEP}} & ~ded_en_q); // R17
    ded_gated_d = ded_gated_now;
    for (int i = 0; i < EIU_N_DED; i++) begin
      ded_level_mode[i] = (eiu_sense_t'(sense_q[2*i +: 2]) == EIU_SENSE_LOW); // R5
      ded_event[i] = warm_q[2] & edge_hit(eiu_sense_t'(sense_q[2*i +: 2]),
                                          ded_gated_now[i], ded_gated_q[i]); // R10 R13
      ded_low_req[i] = ded_level_mode[i] & ~ded_gated_now[i]; // R6 R8
    end
    ded_flag_view = ded_flag_q & ~ded_level_mode; // R16
  end

  // Masked toggles folded into group events
  always_comb begin
    pc_toggle = (pc_if.lvl ^ pc_if.prv) & mask_q & {EIU_N_PC{warm_q[2]}}; // R2
    grp_event = grp_any(pc_toggle); // R1
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------

  // Next values of software-written control bits
  always_comb begin
    sense_d = sense_q;
    ded_en_d = ded_en_q;
    grp_en_d = grp_en_q;
    mask_d = mask_q;
    if (wr_sense) begin
      sense_d = WDATA[EIU_SENSE_MSB:0]; // R5
    end
    if (wr_en) begin
      ded_en_d = WDATA[EIU_N_DED-1:0]; // R9
    end
    if (wr_grp_en) begin
      grp_en_d = WDATA[EIU_N_GRP-1:0]; // R19
    end
    if (WR && (ADDR == EIU_ADR_MASK_LO)) begin
      mask_d[7:0] = WDATA;
    end
    if (WR && (ADDR == EIU_ADR_MASK_MIDLO)) begin
      mask_d[15:8] = WDATA;
    end
    if (WR && (ADDR == EIU_ADR_MASK_MIDHI)) begin
      mask_d[23:16] = WDATA;
    end
    if (WR && (ADDR == EIU_ADR_MASK_HI)) begin
      mask_d[31:24] = WDATA;
    end
  end

  // Control register storage
  always_ff @(posedge CLK) begin
    if (SRST) begin
      sense_q <= EIU_SENSE_RST;
      ded_en_q <= EIU_DED_RST;
      grp_en_q <= EIU_GRP_RST;
      mask_q <= EIU_MASK_RST; // R21
    end else begin
      sense_q <= sense_d;
      ded_en_q <= ded_en_d;
      grp_en_q <= grp_en_d;
      mask_q <= mask_d;
    end
  end

  // ----------------------------------------------------------------
  // Flags
  // ----------------------------------------------------------------

  // Clear by acknowledge or write-one; a new event in the same cycle wins
  always_comb begin
    ded_flag_d = ded_flag_q;
    grp_flag_d = grp_flag_q;
    ded_flag_d = ded_flag_d & ~IRQ_ACK[EIU_N_DED-1:0]; // R15
    grp_flag_d = grp_flag_d & ~IRQ_ACK[EIU_N_REQ-1:EIU_N_DED]; // R20
    if (wr_flags) begin
      ded_flag_d = ded_flag_d & ~WDATA[EIU_N_DED-1:0]; // R15
    end
    if (wr_grp_flags) begin
      grp_flag_d = grp_flag_d & ~WDATA[EIU_N_GRP-1:0]; // R20
    end
    ded_flag_d = (ded_flag_d | ded_event) & ~ded_level_mode; // R13 R16
    grp_flag_d = grp_flag_d | grp_event; // R20
  end

  // Flag storage
  always_ff @(posedge CLK) begin
    if (SRST) begin
      ded_flag_q <= EIU_DED_RST;
      grp_flag_q <= EIU_GRP_RST;
      ded_gated_q <= EIU_DED_RST;
    end else begin
      ded_flag_q <= ded_flag_d;
      grp_flag_q <= grp_flag_d;
      ded_gated_q <= ded_gated_d;
    end
  end

  // ----------------------------------------------------------------
  // Requests and wake
  // ----------------------------------------------------------------

  // One request line per source, gated by own and global enable
  always_comb begin
    req_d = '0;
    for (int i = 0; i < EIU_N_DED; i++) begin
      req_d[i] = GIE & ded_en_q[i] &
                 (ded_level_mode[i] ? ded_low_req[i] : ded_flag_q[i]); // R6 R9 R14 R23
    end
    req_d[EIU_N_REQ-1:EIU_N_DED] = {EIU_N_GRP{GIE}} & grp_en_q & grp_flag_q; // R19 R23
    // Wake needs only the source enable, detection works without I/O clock
    wake_d = SLEEP & (|(ded_en_q & (ded_low_req | ded_flag_q)) |
                      |(grp_en_q & grp_flag_q)); // R3 R7
  end

  // Request storage
  always_ff @(posedge CLK) begin
    if (SRST) begin
      req_q <= '0;
      wake_q <= 1'b0;
    end else begin
      req_q <= req_d;
      wake_q <= wake_d;
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------

  // Status byte: core sleep and enable beside synchronised pin levels
  always_comb begin
    status_byte = EIU_BYTE_ZERO;
    status_byte[EIU_N_DED-1:0] = ded_if.lvl;
    status_byte[EIU_STAT_GIE_BIT] = GIE;
    status_byte[EIU_STAT_SLEEP_BIT] = SLEEP;
  end

  // Read data stands only in the cycle after the strobe
  always_comb begin
    rdata_d = EIU_BYTE_ZERO;
    if (RD) begin
      unique case (ADDR)
        EIU_ADR_SENSE: rdata_d = {2'b00, sense_q}; // R18
        EIU_ADR_ENABLE: rdata_d = {5'h00, ded_en_q};
        EIU_ADR_FLAGS: rdata_d = {5'h00, ded_flag_view}; // R16
        EIU_ADR_GRP_EN: rdata_d = {4'h0, grp_en_q};
        EIU_ADR_GRP_FLAGS: rdata_d = {4'h0, grp_flag_q};
        EIU_ADR_STATUS: rdata_d = status_byte;
        EIU_ADR_MASK_LO: rdata_d = mask_q[7:0];
        EIU_ADR_MASK_MIDLO: rdata_d = mask_q[15:8];
        EIU_ADR_MASK_MIDHI: rdata_d = mask_q[23:16];
        EIU_ADR_MASK_HI: rdata_d = mask_q[31:24];
        default: rdata_d = EIU_BYTE_ZERO;
      endcase
    end
  end

  // Read data register
  always_ff @(posedge CLK) begin
    if (SRST) begin
      rdata_q <= EIU_BYTE_ZERO;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign RDATA = rdata_q;
  assign IRQ_REQ = req_q;
  assign WAKE = wake_q;
endmodule

// ===== src/eiu_pkg.sv
// Package of the external pin interrupt unit: sizes, offsets, resets, codes.
// Assumes a single system clock and a plain byte-wide register port.
package eiu_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int EIU_N_DED = 3;
  localparam int EIU_N_PC = 32;
  localparam int EIU_N_GRP = 4;
  localparam int EIU_GRP_W = 8;
  localparam int EIU_N_REQ = EIU_N_DED + EIU_N_GRP;
  localparam int EIU_AW = 8;
  localparam int EIU_DW = 8;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] EIU_ADR_SENSE = 8'h00;
  localparam logic [7:0] EIU_ADR_ENABLE = 8'h01;
  localparam logic [7:0] EIU_ADR_FLAGS = 8'h02;
  localparam logic [7:0] EIU_ADR_GRP_EN = 8'h03;
  localparam logic [7:0] EIU_ADR_GRP_FLAGS = 8'h04;
  localparam logic [7:0] EIU_ADR_STATUS = 8'h05;
  localparam logic [7:0] EIU_ADR_MASK_LO = 8'h6B;
  localparam logic [7:0] EIU_ADR_MASK_MIDLO = 8'h6C;
  localparam logic [7:0] EIU_ADR_MASK_MIDHI = 8'h6D;
  localparam logic [7:0] EIU_ADR_MASK_HI = 8'h73;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int EIU_SENSE_MSB = 5;
  localparam int EIU_STAT_GIE_BIT = 3;
  localparam int EIU_STAT_SLEEP_BIT = 4;
  localparam logic [5:0] EIU_SENSE_RST = 6'h00;
  localparam logic [2:0] EIU_DED_RST = 3'h0;
  localparam logic [3:0] EIU_GRP_RST = 4'h0;
  localparam logic [31:0] EIU_MASK_RST = 32'h0000_0000;
  localparam logic [7:0] EIU_BYTE_ZERO = 8'h00;

  // ----------------------------------------------------------------
  // Sense codes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    EIU_SENSE_LOW = 2'b00,
    EIU_SENSE_ANY = 2'b01,
    EIU_SENSE_FALL = 2'b10,
    EIU_SENSE_RISE = 2'b11
  } eiu_sense_t;

endpackage

// ===== src/eiu_pin_if.sv
// Interface carrying synchronised pin levels between the unit's modules.
// Assumes both ends run on the same system clock.
`timescale 1ns/10ps

interface eiu_pin_if #(
  parameter int W = 8
);
  logic [W-1:0] lvl; // Synchronised level
  logic [W-1:0] prv; // Level one clock earlier

  // ----------------------------------------------------------------
  // Modports
  // ----------------------------------------------------------------
  modport src (output lvl, output prv);
  modport dst (input lvl, input prv);
endinterface

// ===== src/eiu_sync.sv
// Two-flop synchroniser with one extra stage for change detection.
// Assumes inputs come from pins outside the system clock domain.
`timescale 1ns/10ps

module eiu_sync #(
  parameter int W = 8
) (
  input wire logic clk, // System clock
  input wire logic srst, // Synchronous reset, high
  input wire logic [W-1:0] async_in, // Raw pin levels
  eiu_pin_if.src pin // Synchronised levels out
);
  import eiu_pkg::*;

  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] lvl_q;
  logic [W-1:0] lvl_d;
  logic [W-1:0] prv_q;
  logic [W-1:0] prv_d;

  // Next values: first stage feeds only the second
  always_comb begin
    meta_d = async_in;
    lvl_d = meta_q;
    prv_d = lvl_q;
  end

  // Stage registers
  always_ff @(posedge clk) begin
    if (srst) begin
      meta_q <= '0;
      lvl_q <= '0;
      prv_q <= '0;
    end else begin
      meta_q <= meta_d;
      lvl_q <= lvl_d;
      prv_q <= prv_d;
    end
  end

  assign pin.lvl = lvl_q;
  assign pin.prv = prv_q;
endmodule

// ===== tb/eiu_checker.sv
// Checker of the pin interrupt unit, bound to the top module's ports.
// Assumes the offsets and the request order of eiu_pkg.
`timescale 1ns/10ps

module eiu_checker (
  input wire logic CLK, // Clock
  input wire logic SRST, // Reset
  input wire logic [7:0] ADDR, // Address
  input wire logic [7:0] WDATA, // Write data
  input wire logic WR, // Write strobe
  input wire logic RD, // Read strobe
  input wire logic [7:0] RDATA, // Read data
  input wire logic [2:0] DED_IRQ_PINS, // Pins
  input wire logic [31:0] PIN_CHANGE_INPUTS, // Change pins
  input wire logic GIE, // Global enable
  input wire logic SLEEP, // Sleep
  input wire logic [6:0] IRQ_ACK, // Acks
  input wire logic [6:0] IRQ_REQ, // Requests
  input wire logic WAKE // Wake
);
  import eiu_pkg::*;
  logic [5:0] sns_q, sns_d;
  logic [6:0] en_q, en_d;
  logic [2:0] lvl_m;
  // ----------------
  // Register shadow
  // ----------------
  // Next values of sense and enable copies
  always_comb begin
    sns_d = sns_q;
    en_d = en_q;
    if (WR && ADDR == EIU_ADR_SENSE) sns_d = WDATA[5:0];
    if (WR && ADDR == EIU_ADR_ENABLE) en_d[2:0] = WDATA[2:0];
    if (WR && ADDR == EIU_ADR_GRP_EN) en_d[6:3] = WDATA[3:0];
    if (SRST) sns_d = 6'h00;
    if (SRST) en_d = 7'h00;
  end
  // Register the copies
  always_ff @(posedge CLK) begin
    sns_q <= sns_d;
    en_q <= en_d;
  end
  // Pins in low-level sense
  assign lvl_m = {sns_q[5:4] == 2'b00, sns_q[3:2] == 2'b00, sns_q[1:0] == 2'b00};

  default clocking dc @(posedge CLK);
  endclocking
  default disable iff (SRST);

  a_sense_rsvd: assert property (RD && ADDR == EIU_ADR_SENSE |=> RDATA[7:6] == 2'b00)
    else $error("sense reserved bits not zero");
  a_flag_lvl: assert property (RD && ADDR == EIU_ADR_FLAGS |=> (RDATA[2:0] & $past(lvl_m)) == 3'h0)
    else $error("level pin flag reads set");
  a_gie_gate: assert property (!GIE && !$past(GIE) |-> IRQ_REQ == 7'h00)
    else $error("request without global enable");
  a_en_gate: assert property ((IRQ_REQ & ~en_q & ~$past(en_q)) == 7'h00)
    else $error("request without its enable");
  a_level_hold: assert property ((lvl_m[0] && en_q[0] && GIE && !DED_IRQ_PINS[0]) [*5] |-> IRQ_REQ[0])
    else $error("low level not requesting");
  a_level_idle: assert property ((lvl_m[0] && DED_IRQ_PINS[0]) [*5] |-> !IRQ_REQ[0])
    else $error("level request with pin high");
  a_ack_clear: assert property (($stable(DED_IRQ_PINS[1]) [*5]) ##0 (IRQ_ACK[1] && !lvl_m[1])
    ##1 $stable(DED_IRQ_PINS[1]) |=> !IRQ_REQ[1])
    else $error("request kept after routine entry");
  a_wake_lvl: assert property ((SLEEP && en_q[0] && lvl_m[0] && !DED_IRQ_PINS[0]) [*5] |-> WAKE)
    else $error("low level does not wake");
  a_wake_awake: assert property (!SLEEP && !$past(SLEEP) |-> !WAKE)
    else $error("wake while awake");

  c_ack: cover property (IRQ_ACK != 7'h00);
  c_wake: cover property (WAKE);
  c_grp: cover property (IRQ_REQ[6:3] != 4'h0);
endmodule

bind eiu_top eiu_checker u_chk (.CLK(CLK), .SRST(SRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
  .RD(RD), .RDATA(RDATA), .DED_IRQ_PINS(DED_IRQ_PINS), .PIN_CHANGE_INPUTS(PIN_CHANGE_INPUTS),
  .GIE(GIE), .SLEEP(SLEEP), .IRQ_ACK(IRQ_ACK), .IRQ_REQ(IRQ_REQ), .WAKE(WAKE));

// ===== tb/eiu_core_mdl.sv
// Core model: enters the routine of a pending request after a delay.
// Assumes requests from the unit on the one system clock.
`timescale 1ns/10ps

module eiu_core_mdl (
  input wire logic clk, // Clock
  input wire logic srst, // Reset, high
  input wire logic [6:0] req, // Requests in
  input wire logic [6:0] take, // Sources served
  input wire logic [3:0] dly, // Wait, 2 or more
  output logic [6:0] ack // Routine entry pulses
);
  logic [6:0] pend;
  int n;
  assign pend = req & take;
  // Pulse the lowest pending source once its wait runs out
  always @(posedge clk) begin
    ack <= 7'h00;
    n <= n + 1;
    if (srst || ack != 7'h00 || pend == 7'h00) begin
      n <= 0;
    end else if (n >= int'(dly)) begin
      ack <= pend & (~pend + 7'h01);
    end
  end
endmodule

// ===== tb/tb_external_pin_interrupt_unit.sv
// Bench of the pin interrupt unit, with a core model serving requests.
// Assumes eiu_pkg, eiu_top and eiu_core_mdl.
`timescale 1ns/10ps

module tb_external_pin_interrupt_unit;
  import eiu_pkg::*;
  logic clk, srst, wr, rd, gie, slp, wake;
  logic [7:0] addr, wdata, rdata, v;
  logic [2:0] pins;
  logic [31:0] pcin;
  logic [6:0] ack, req, take;
  logic [3:0] dly;
  int err_count, checked, seed, cyc, x, r;
  int img[0:255];
  logic [7:0] adl[8] = '{8'h00, 8'h01, 8'h03, 8'h6B, 8'h6C, 8'h6D, 8'h73, 8'h40};
  logic [7:0] madr[4] = '{8'h6B, 8'h6C, 8'h6D, 8'h73};

  eiu_top dut (.CLK(clk), .SRST(srst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .DED_IRQ_PINS(pins), .PIN_CHANGE_INPUTS(pcin), .GIE(gie),
    .SLEEP(slp), .IRQ_ACK(ack), .IRQ_REQ(req), .WAKE(wake));
  eiu_core_mdl u_core (.clk(clk), .srst(srst), .req(req), .take(take), .dly(dly), .ack(ack));

  // Clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Cycle ceiling
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      results();
    end
  end

  // -----------
  // Bus and checks
  // -----------
  function automatic logic [7:0] wm(input logic [7:0] a);
    case (a)
      EIU_ADR_SENSE: return 8'h3F;
      EIU_ADR_ENABLE: return 8'h07;
      EIU_ADR_GRP_EN: return 8'h0F;
      EIU_ADR_MASK_LO, EIU_ADR_MASK_MIDLO, EIU_ADR_MASK_MIDHI, EIU_ADR_MASK_HI: return 8'hFF;
      default: return 8'h00;
    endcase
  endfunction
  task automatic mw(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    img[a] = int'(d & wm(a));
  endtask
  task automatic rdr(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t reg %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chq(input logic [6:0] exp);
    #1;
    checked++;
    if (req !== exp) begin
      err_count++;
      $display("[ERR] %0t req %h exp %h", $time, req, exp);
    end
  endtask
  task automatic results();
    if (err_count == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    seed = 23161;
    srst = 1'b1;
    {wr, rd, gie, slp} = 4'h0;
    addr = 8'h00;
    wdata = 8'h00;
    pins = 3'h7;
    pcin = 32'h0;
    take = 7'h00;
    dly = 4'd2;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    for (int k = 0; k < 3; k++) begin
      foreach (adl[i]) begin
        rdr(adl[i], v);
        chk(v, 8'(img[adl[i]]));
        mw(adl[i], (k == 1) ? 8'h00 : 8'($random(seed)));
      end
    end
    foreach (adl[i]) mw(adl[i], 8'h00);
    mw(EIU_ADR_FLAGS, 8'h07);
    mw(EIU_ADR_GRP_FLAGS, 8'h0F);
    gie <= 1'b1;
    for (int n = 0; n < 3; n++) begin
      for (int c = 1; c < 4; c++) begin
        for (int e = 0; e < 2; e++) begin
          mw(EIU_ADR_ENABLE, 8'h00);
          pins <= e ? 3'h0 : 3'h7;
          repeat (6) @(posedge clk);
          mw(EIU_ADR_SENSE, 8'(c << (2 * n)));
          mw(EIU_ADR_FLAGS, 8'h07);
          mw(EIU_ADR_ENABLE, 8'(1 << n));
          pins <= e ? 3'h7 : 3'h0;
          repeat (6) @(posedge clk);
          x = (c == 1 || (c == 2 && e == 0) || (c == 3 && e == 1)) ? 1 : 0;
          chq(7'(x << n));
          rdr(EIU_ADR_FLAGS, v);
          chk(v, 8'(x << n));
          mw(EIU_ADR_FLAGS, 8'(1 << n));
          repeat (2) @(posedge clk);
          chq(7'h00);
        end
      end
    end
    for (int k = 2; k < 12; k += 7) begin
      mw(EIU_ADR_ENABLE, 8'h00);
      pins <= 3'h5;
      repeat (6) @(posedge clk);
      mw(EIU_ADR_SENSE, 8'h0C);
      mw(EIU_ADR_FLAGS, 8'h07);
      mw(EIU_ADR_ENABLE, 8'h02);
      dly <= 4'(k);
      take <= 7'h7F;
      pins <= 3'h7;
      repeat (25) @(posedge clk);
      chq(7'h00);
      rdr(EIU_ADR_FLAGS, v);
      chk(v, 8'h00);
      @(posedge clk);
      take <= 7'h00;
    end
    mw(EIU_ADR_ENABLE, 8'h00);
    mw(EIU_ADR_SENSE, 8'h00);
    mw(EIU_ADR_ENABLE, 8'h01);
    pins <= 3'h6;
    repeat (6) @(posedge clk);
    chq(7'h01);
    rdr(EIU_ADR_FLAGS, v);
    chk(v, 8'h00);
    @(posedge clk);
    gie <= 1'b0;
    repeat (3) @(posedge clk);
    chq(7'h00);
    @(posedge clk);
    slp <= 1'b1;
    repeat (6) @(posedge clk);
    #1 chk({7'h00, wake}, 8'h01);
    rdr(EIU_ADR_STATUS, v);
    chk(v, 8'h16);
    @(posedge clk);
    slp <= 1'b0;
    gie <= 1'b1;
    pins <= 3'h7;
    repeat (6) @(posedge clk);
    chq(7'h00);
    mw(EIU_ADR_SENSE, 8'h08);
    mw(EIU_ADR_FLAGS, 8'h07);
    slp <= 1'b1;
    repeat (6) @(posedge clk);
    rdr(EIU_ADR_FLAGS, v);
    chk(v, 8'h02);
    @(posedge clk);
    slp <= 1'b0;
    mw(EIU_ADR_ENABLE, 8'h00);
    mw(EIU_ADR_GRP_EN, 8'h0F);
    for (int g = 0; g < 4; g++) begin
      r = int'($unsigned($random(seed)) % 8);
      mw(madr[g], 8'(1 << r));
      mw(EIU_ADR_GRP_FLAGS, 8'h0F);
      pcin <= pcin ^ (32'h1 << (8 * g + (r + 1) % 8));
      repeat (6) @(posedge clk);
      chq(7'h00);
      @(posedge clk);
      pcin <= pcin ^ (32'h1 << (8 * g + r));
      repeat (6) @(posedge clk);
      chq(7'(8 << g));
      rdr(EIU_ADR_GRP_FLAGS, v);
      chk(v, 8'(1 << g));
      mw(EIU_ADR_GRP_FLAGS, 8'(1 << g));
      repeat (2) @(posedge clk);
      chq(7'h00);
      mw(madr[g], 8'h00);
    end
    results();
  end
endmodule
